/* File: usb_host_revision_control_regs.sv */
// Interface version and operating-mode control registers of a USB host.
// Assumes a parallel port strobe held until data is taken; one clock.
module usb_host_revision_control_regs
  import usb_host_revision_control_pkg::*;
#(
  // Version byte; value is arbitrary
  parameter logic [7:0] VERSION_BCD = 8'h01
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Parallel command port
  input  wire logic        busStrobe,
  input  wire logic [7:0]  busCode,
  input  wire logic [31:0] busWrData,
  output logic      [31:0] busRdData,
  output logic             busRdValid,
  // Status from the rest of the host
  input  wire logic        softReset,
  input  wire logic        resumeSeenFlag,
  // Control outputs
  output logic             remoteWakeEnable,
  output logic             remoteWakeConnected,
  output logic      [1:0]  hostFunctionalState,
  output logic             remoteWake,
  output logic             rootHubReset
);
  logic  rstMeta_n;   // Reset release, first stage
  logic  rstSync_n;   // Reset release, used by all logic
  logic  strobeSync;  // Strobe after two flip-flops
  logic  takeCmd;     // Rising strobe: command taken
  regs_s st;          // Registered state
  regs_s next_st;     // Next state
  logic  [`PORT_SYNC_BITS-1:0] portPins;  // Code and data pins together
  logic  [`PORT_SYNC_BITS-1:0] portSync;  // Same bits after two flip-flops
  logic  [7:0]                 codeSync;  // Command code, synchronised
  logic  [31:0]              wrDataSync;  // Write data, synchronised

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // Strobe pin synchroniser
  strobe_sync u_strobe_sync (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .pinLevel  (busStrobe),
    .syncLevel (strobeSync)
  );

  // Code and data pins, each bit through two flip-flops, so they line up
  // with the synchronised strobe and are never read straight off the pins
  assign portPins = {busWrData, busCode};
  for (genvar i = 0; i < `PORT_SYNC_BITS; i++) begin : g_port_sync
    strobe_sync u_port_sync (
      .clk_sys   (clk_sys),
      .rstSync_n (rstSync_n),
      .pinLevel  (portPins[i]),
      .syncLevel (portSync[i])
    );
  end
  assign {wrDataSync, codeSync} = portSync;

  // Command taken once per strobe rising edge
  assign takeCmd = strobeSync && !st.strobePrev;

  // Next-state logic
  always_comb begin
    next_st            = st;
    next_st.strobePrev = strobeSync;
    next_st.rdValid    = 1'b0;
    // Hub reset ends once the hardware reset has released
    next_st.rootHubReset = 1'b0;
    if (takeCmd) begin
      case (codeSync)
        // Version word, upper bits zero
        `CMD_VERSION_RD: begin
          next_st.rdData = `RD_RESET_WORD;
          next_st.rdData[`VER_HI:`VER_LO] = VERSION_BCD;
          next_st.rdValid = 1'b1;
        end
        // Control word read back
        `CMD_CONTROL_RD: begin
          next_st.rdData = `RD_RESET_WORD;
          next_st.rdData[`CTL_WAKE_EN_BIT]  = st.wakeEnable;
          next_st.rdData[`CTL_WAKE_CON_BIT] = st.wakeConnected;
          next_st.rdData[`CTL_STATE_HI:`CTL_STATE_LO] = st.hostState;
          next_st.rdValid = 1'b1;
        end
        // Control word write; only software moves wake enable
        `CMD_CONTROL_WR: begin
          next_st.wakeEnable    = wrDataSync[`CTL_WAKE_EN_BIT];
          next_st.wakeConnected = wrDataSync[`CTL_WAKE_CON_BIT];
          next_st.hostState     = host_state_e'(
            wrDataSync[`CTL_STATE_HI:`CTL_STATE_LO]);
        end
        // Unmapped code: answer with zero
        default: begin
          next_st.rdData  = `RD_RESET_WORD;
          next_st.rdValid = 1'b1;
        end
      endcase
    end
    // Software reset: reset state, wake connected kept
    if (softReset) begin
      next_st.hostState = STATE_RESET;
      next_st.wakeConnected = st.wakeConnected;
    end
    // Wake request, independent of any interrupt path
    next_st.remoteWake = st.wakeEnable && resumeSeenFlag;
  end

  // State register; hardware reset clears everything except rootHubReset, which it sets
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st.strobePrev    <= 1'b0;
      st.wakeEnable    <= 1'b0;
      st.wakeConnected <= 1'b0;
      st.hostState     <= STATE_RESET;
      st.rdData        <= `RD_RESET_WORD;
      st.rdValid       <= 1'b0;
      st.remoteWake    <= 1'b0;
      st.rootHubReset  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign busRdData           = st.rdData;
  assign busRdValid          = st.rdValid;
  assign remoteWakeEnable    = st.wakeEnable;
  assign remoteWakeConnected = st.wakeConnected;
  assign hostFunctionalState = st.hostState;
  assign remoteWake          = st.remoteWake;
  assign rootHubReset        = st.rootHubReset;

  // Version read answers with a valid pulse and zero upper bits
  a_version_read: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    takeCmd && codeSync == `CMD_VERSION_RD |=>
      busRdValid && busRdData[`VER_RSV_HI:`VER_RSV_LO] == '0)
    else $error("version upper bits not zero");

  // Version byte is the fixed parameter, whatever was written
  a_version_value: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    takeCmd && codeSync == `CMD_VERSION_RD |=>
      busRdData[`VER_HI:`VER_LO] == VERSION_BCD)
    else $error("version byte wrong");

  // Control read returns every stored field
  a_control_read: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    takeCmd && codeSync == `CMD_CONTROL_RD |=>
      busRdValid
      && busRdData[`CTL_WAKE_EN_BIT] == $past(st.wakeEnable)
      && busRdData[`CTL_WAKE_CON_BIT] == $past(st.wakeConnected)
      && busRdData[`CTL_STATE_HI:`CTL_STATE_LO] == $past(st.hostState))
    else $error("control read mismatch");

  // Read answer pulse stands for exactly one cycle
  a_valid_pulse: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    busRdValid |=> !busRdValid)
    else $error("read answer longer than one cycle");

  a_wake_en_hold: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    !(takeCmd && codeSync == `CMD_CONTROL_WR) |=> $stable(remoteWakeEnable))
    else $error("wake enable changed without write");

  a_wake_signal: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    remoteWakeEnable && resumeSeenFlag && !softReset
      && !(takeCmd && codeSync == `CMD_CONTROL_WR) ##1 resumeSeenFlag
      |-> remoteWake)
    else $error("wake not signalled");

  // No wake request while the enable was clear
  a_wake_disabled: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    !$past(remoteWakeEnable) |-> !remoteWake)
    else $error("wake while disabled");

  a_wake_none: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    !$past(resumeSeenFlag) |-> !remoteWake)
    else $error("wake without resume");

  a_connected_soft: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    softReset && !(takeCmd && codeSync == `CMD_CONTROL_WR)
      |=> $stable(remoteWakeConnected))
    else $error("soft reset changed wake connected");

  a_soft_state: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    softReset |=> hostFunctionalState == STATE_RESET)
    else $error("soft reset missed reset state");

  // Hub reset, set by the hardware reset, lasts one cycle past its release
  a_hub_pulse: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    rootHubReset |=> !rootHubReset)
    else $error("hub reset held too long");

  a_write_store: assert property (
    @(posedge clk_sys) disable iff (!rstSync_n)
    takeCmd && codeSync == `CMD_CONTROL_WR && !softReset |=>
      hostFunctionalState == $past(wrDataSync[`CTL_STATE_HI:`CTL_STATE_LO])
      && remoteWakeConnected == $past(wrDataSync[`CTL_WAKE_CON_BIT])
      && remoteWakeEnable == $past(wrDataSync[`CTL_WAKE_EN_BIT]))
    else $error("control write not stored");
endmodule

/* File: usb_host_revision_control_defines.svh */
// Constants for the host revision and operating-mode register pair.
// Assumes inclusion by bare name from the package only; the top module uses the macros without including it.
`ifndef USB_HOST_REVISION_CONTROL_DEFINES_SVH
`define USB_HOST_REVISION_CONTROL_DEFINES_SVH

// Command codes seen on the parallel port
`define CMD_VERSION_RD   8'h00
`define CMD_CONTROL_RD   8'h01
`define CMD_CONTROL_WR   8'h81

// Field positions inside the operating-mode control word
`define CTL_WAKE_EN_BIT  10
`define CTL_WAKE_CON_BIT 9
`define CTL_STATE_HI     7
`define CTL_STATE_LO     6

// Field position of the version number
`define VER_HI           7
`define VER_LO           0
`define VER_RSV_HI       31
`define VER_RSV_LO       8

// Code and data pin bits that pass the synchronisers
`define PORT_SYNC_BITS   40

// Reset values
`define CTL_RESET_WORD   32'h0000_0000
`define RD_RESET_WORD    32'h0000_0000

`endif

/* File: usb_host_revision_control_pkg.sv */
// Types shared by the revision and operating-mode register pair.
// Assumes the defines header sits in the same folder.
package usb_host_revision_control_pkg;
  `include "usb_host_revision_control_defines.svh"

  // Host functional state encodings
  typedef enum logic [1:0] {
    STATE_RESET       = 2'b00,  // Bus held in reset
    STATE_RESUME      = 2'b01,  // Resume signalling
    STATE_OPERATIONAL = 2'b10,  // Normal traffic
    STATE_SUSPEND     = 2'b11   // Suspended
  } host_state_e;

  // Register state of the top module, apart from the reset and pin synchronisers
  typedef struct packed {
    logic        strobePrev;        // Last synchronised strobe level
    logic        wakeEnable;        // Remote wake enable
    logic        wakeConnected;     // Remote wake connected
    host_state_e hostState;         // Host functional state
    logic [31:0] rdData;            // Read answer word
    logic        rdValid;           // Read answer pulse
    logic        remoteWake;        // Wake request toward system
    logic        rootHubReset;      // Root hub and port reset
  } regs_s;
endpackage

/* File: strobe_sync.sv */
// Two-stage synchroniser for one asynchronous pin level.
// Assumes one system clock and an already synchronised active-low reset.
module strobe_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstSync_n,
  // Pin side
  input  wire logic pinLevel,
  // Clock domain side
  output logic      syncLevel
);
  logic stage1;  // Read only by the second stage

  // Two flip-flops in series
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage1    <= 1'b0;
      syncLevel <= 1'b0;
    end else begin
      stage1    <= pinLevel;
      syncLevel <= stage1;
    end
  end
endmodule

/* File: host_port_model.sv */
// Host processor model driving the parallel command port of the registers.
// Assumes the port samples on rising edges and answers reads with a pulse.
module host_port_model (
  // Clock
  input  wire logic        clk_sys,
  // Command port
  output logic             busStrobe,
  output logic [7:0]       busCode,
  output logic [31:0]      busWrData,
  input  wire logic [31:0] busRdData,
  input  wire logic        busRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port shows no stale command
  initial begin
    busStrobe = 1'b0;
    busCode   = 8'h5a;
    busWrData = 32'h5a5a_5a5a;
  end
  // One strobe; reads hold until the answer pulse, writes a fixed time
  task automatic access(input logic [7:0] code, input logic [31:0] wdata,
                        input bit isRead, output logic [31:0] rdata,
                        output bit ok);
    ok = !isRead;
    rdata = '0;
    @(negedge clk_sys);
    busStrobe <= 1'b1;
    busCode   <= code;
    busWrData <= wdata;
    // Bounded wait for the answer
    for (int n = 0; n < 12 && !ok; n++) begin
      @(posedge clk_sys);
      if (busRdValid) begin
        rdata = busRdData;
        ok = 1'b1;
      end
    end
    if (!isRead) begin
      repeat (4) @(posedge clk_sys);
    end
    // Release: lines no longer carry the old command
    @(negedge clk_sys);
    busStrobe <= 1'b0;
    busCode   <= ~code;
    busWrData <= ~wdata;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

/* File: test_usb_host_revision_control_regs.sv */
// Self-checking bench for the revision and operating-mode registers.
// Assumes the host port model is compiled before this file.
module test_usb_host_revision_control_regs;
  import usb_host_revision_control_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VER = 8'h42;  // Arbitrary version byte
  logic        clk_sys = 1'b0;         // System clock
  logic        rst_n = 1'b0;           // Hardware reset
  logic        softReset = 1'b0;       // Software reset
  logic        resumeSeenFlag = 1'b0;  // Resume status level
  logic        busStrobe, busRdValid, remoteWake, rootHubReset;
  logic        remoteWakeEnable, remoteWakeConnected;
  logic [7:0]  busCode;
  logic [31:0] busWrData, busRdData, rdv;
  logic [1:0]  hostFunctionalState;
  int          errors = 0;
  int          comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  usb_host_revision_control_regs #(.VERSION_BCD(VER)) dut_u (.clk_sys,
    .rst_n, .busStrobe, .busCode, .busWrData, .busRdData, .busRdValid,
    .softReset, .resumeSeenFlag, .remoteWakeEnable, .remoteWakeConnected,
    .hostFunctionalState, .remoteWake, .rootHubReset);
  host_port_model host (.clk_sys, .busStrobe, .busCode, .busWrData,
    .busRdData, .busRdValid);
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic stop_test;
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rd(logic [7:0] code, output logic [31:0] data);
    bit ok;
    host.access(code, '0, 1'b1, data, ok);
    if (!ok) begin
      $display("Error read answer expected 1 seen 0");
      errors++;
      stop_test();
    end
  endtask
  task automatic wr(logic [7:0] code, logic [31:0] data);
    logic [31:0] unused;
    bit ok;
    host.access(code, data, 1'b0, unused, ok);
  endtask
  task automatic hw_reset;
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("hub reset held", 1, rootHubReset);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("hub reset released", 0, rootHubReset);
  endtask
  // Version word fixed; control word zero after reset
  task automatic test_version;
    rd(8'h00, rdv);
    check("version", {24'h0, VER}, rdv);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h00, rdv);
    check("version kept", {24'h0, VER}, rdv);
    rd(8'h01, rdv);
    check("control reset", 0, rdv);
    rd(8'h02, rdv);
    check("unmapped", 0, rdv);
    $display("test_version done");
  endtask
  // Every state code stored; reserved bits dropped
  task automatic test_states;
    for (int s = 0; s < 4; s++) begin
      wr(8'h81, 32'hffff_f93f | (s << 6));
      rd(8'h01, rdv);
      check("control", s << 6, rdv);
      check("state out", s, hostFunctionalState);
    end
    $display("test_states done");
  endtask
  // Wake follows enable and resume status
  task automatic test_wake;
    wr(8'h81, 32'h0000_0680);
    resumeSeenFlag = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("wake", 1, remoteWake);
    check("enable kept", 1, remoteWakeEnable);
    wr(8'h81, 32'h0000_0280);
    check("wake off", 0, remoteWake);
    resumeSeenFlag = 1'b0;
    $display("test_wake done");
  endtask
  // Software reset keeps connected bit; hardware reset clears the control word
  task automatic test_resets;
    wr(8'h81, 32'h0000_0680);
    softReset = 1'b1;
    @(negedge clk_sys);
    softReset = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("state soft", 0, hostFunctionalState);
    check("connected soft", 1, remoteWakeConnected);
    rd(8'h01, rdv);
    check("control soft", 32'h0000_0600, rdv);
    hw_reset();
    check("connected hard", 0, remoteWakeConnected);
    rd(8'h01, rdv);
    check("control hard", 0, rdv);
    $display("test_resets done");
  endtask
  initial begin
    hw_reset();
    test_version();
    test_states();
    test_wake();
    test_resets();
    stop_test();
  end
endmodule
